// ---- verilog/pat_pkg.sv ----
// pat_pkg: shared constants of the pci bridge address translation block
// assumes a single 250 MHz clock domain and 32-bit pci addresses
package pat_pkg;
  // translation table window on the control register slave port
  localparam logic [15:0] TBL_LO = 16'h1000;
  localparam logic [15:0] TBL_HI = 16'h1fff;
  localparam int ENTRY_LOG2 = 3;
  // address space indicator codes in entry bits 1:0
  localparam logic [1:0] SP_MEM = 2'h0;
  localparam logic [1:0] SP_RSV = 2'h1;
  localparam logic [1:0] SP_IO = 2'h2;
  localparam logic [1:0] SP_CFG = 2'h3;
  // configuration request type codes in address bits 1:0
  localparam logic [1:0] CFG_T0 = 2'h0;
  localparam logic [1:0] CFG_T1 = 2'h1;
  // longest wait state on the pci access slave port, in cycles
  localparam logic [2:0] WAIT_MAX = 3'h6;
  // sizes
  localparam int PAGE_BITS_DEF = 12;
  localparam int AV_ADDR_W_DEF = 20;
  localparam int BUF_DEPTH_DEF = 128;
  localparam int LEN_W = 8;
  localparam int NUM_BARS = 3;
  localparam logic [1:0] BAR_PF = 2'h0;
  localparam logic [1:0] BAR_NP = 2'h1;
  localparam logic [1:0] BAR_IO = 2'h2;
endpackage

// ---- verilog/pat_dpram.sv ----
// pat_dpram: simple dual-port memory, one write port, one registered read port
// assumes both ports on sys_clk; a read of a word written in the same cycle sees the old word
`timescale 1ns/1ps
module pat_dpram #(
  parameter int W = 32,
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // write port
  input wire logic wen,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // read port
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge sys_clk)
  begin
    if (wen)
      mem[waddr] <= wdata;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      rdata <= '0;
    else
      rdata <= mem[raddr];
  end
endmodule

// ---- verilog/pat_bridge.sv ----
// pat_bridge: address translation and transaction acceptance of a pci bridge
// assumes synchronous inputs on sys_clk; lengths never exceed BUF_DEPTH
`timescale 1ns/1ps
// Summary of operation
// - outbound pci reads: only one may be in flight at a time.
// - pci access slave port holds an interconnect master at most 6 cycles.
// - prefetchable target accesses go through a dual-port buffer, bursting both sides.
// - each bar type has its own master port; only prefetchable bursts.
// - all target reads are delayed reads; one at a time, others retried.
// - inbound matched address bits are replaced by that bar's local base.
// - outbound low bits pass; upper bits index table; entry gives upper bits.
// - page size sets table entry count and pass-through bit count.
// - each entry holds a two-bit space code in bits 1:0.
// - code 00 is 32-bit memory, high entry word ignored; 01 reserved.
// - code 10 is i/o space with low-bit rewrite.
// - code 11 is configuration space, read as type 1 layout then rewritten.
// - i/o bits 2:0 point to first enabled byte; bits 31:3 translate.
// - i/o bit 2 rewritten only on a 64-bit data path.
// - configuration with bus number zero sets bits 1:0 to 00.
// - type 0 keeps bits 10:2 from the translated address.
// - type 0 bits 31:11 are one-hot of device number 15:11, all zero for device numbers above 20.
// - type 0 ignores translated bits 31:24.
// - nonzero bus sets bits 1:0 to 01, keeps bits 31:2.
// - entries are 8 bytes; pass-through bits above bits 1:0 are unwritable, held zero.
// - table written only via control port 0x1000-0x1fff, interconnect writes only.
module pat_bridge #(
  parameter int PAGE_BITS = pat_pkg::PAGE_BITS_DEF,
  parameter int AW = pat_pkg::AV_ADDR_W_DEF,
  parameter bit DATA64 = 1'b0,
  parameter int BUF_DEPTH = pat_pkg::BUF_DEPTH_DEF,
  parameter logic [pat_pkg::NUM_BARS*32-1:0] BAR_MASK = {32'hffff_0000, 32'hffff_f000, 32'hfff0_0000},
  parameter logic [pat_pkg::NUM_BARS*32-1:0] LOCAL_BASE = {32'h0003_0000, 32'h0002_0000, 32'h0010_0000},
  localparam int BE_W = DATA64 ? 8 : 4,
  localparam int IDX_W = AW - PAGE_BITS,
  localparam int BW = $clog2(BUF_DEPTH)
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // control register slave port, table writes
  input wire logic ctl_write,
  input wire logic [15:0] ctl_addr,
  input wire logic [31:0] ctl_wdata,
  input wire logic ctl_from_pci,
  // pci access slave port
  input wire logic pas_read,
  input wire logic pas_write,
  input wire logic [AW-1:0] pas_addr,
  input wire logic [BE_W-1:0] pas_byteen,
  output logic pas_waitrequest,
  output logic pas_refused,
  output logic pas_space_err,
  // pci master request
  output logic pm_valid,
  input wire logic pm_ready,
  output logic pm_read,
  output logic [1:0] pm_space,
  output logic [31:0] pm_addr,
  output logic [BE_W-1:0] pm_byteen,
  input wire logic pm_rd_done,
  // pci target side
  input wire logic [pat_pkg::NUM_BARS*32-1:0] bar_base,
  input wire logic tgt_req,
  input wire logic tgt_read,
  input wire logic [31:0] tgt_addr,
  input wire logic [pat_pkg::LEN_W-1:0] tgt_len,
  output logic tgt_accept,
  output logic tgt_retry,
  input wire logic tgt_wvalid,
  input wire logic [31:0] tgt_wdata,
  output logic tgt_rvalid,
  input wire logic tgt_rready,
  output logic [31:0] tgt_rdata,
  // local master ports, one valid per bar type
  output logic [pat_pkg::NUM_BARS-1:0] lm_valid,
  output logic lm_read,
  output logic [31:0] lm_addr,
  output logic [pat_pkg::LEN_W-1:0] lm_burst,
  output logic [31:0] lm_wdata,
  input wire logic lm_waitrequest,
  input wire logic lm_rvalid,
  input wire logic [31:0] lm_rdata
);
  typedef enum logic [2:0] {O_IDLE = 3'b001, O_LOOK = 3'b010, O_ISSUE = 3'b100} pat_out_e;
  typedef enum logic [5:0] {T_IDLE = 6'b000001, T_WFILL = 6'b000010, T_WDRAIN = 6'b000100,
    T_RFETCH = 6'b001000, T_RHOLD = 6'b010000, T_RSEND = 6'b100000} pat_tgt_e;
  localparam logic [pat_pkg::LEN_W-1:0] ONE = 8'h01;

  pat_out_e o_state;
  pat_tgt_e t_state;
  logic [31:0] low_mask, tbl_rdata, xl, next_pm_addr;
  logic tw_en, o_read, rd_busy, pas_req, accept;
  logic [AW-1:0] o_addr;
  logic [BE_W-1:0] o_be;
  logic [2:0] wait_cnt, pos;
  // --------------------------------------------------------------
  // translation table
  // --------------------------------------------------------------
  assign low_mask = (32'h1 << PAGE_BITS) - 32'h1;
  // only interconnect writes to the low word of an implemented entry
  assign tw_en = ctl_write && !ctl_from_pci && ctl_addr >= pat_pkg::TBL_LO && ctl_addr <= pat_pkg::TBL_HI
    && !ctl_addr[2] && ((ctl_addr[11:pat_pkg::ENTRY_LOG2] >> IDX_W) == 9'h000);

  pat_dpram #(.W(32), .DEPTH(1 << IDX_W), .AW(IDX_W)) u_table (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .wen(tw_en),
    .waddr(ctl_addr[pat_pkg::ENTRY_LOG2 +: IDX_W]),
    .wdata(ctl_wdata & (~low_mask | 32'h3)),
    .raddr(pas_addr[AW-1:PAGE_BITS]),
    .rdata(tbl_rdata)
  );

  // --------------------------------------------------------------
  // pci access slave port
  // --------------------------------------------------------------
  assign pas_req = pas_read || pas_write;
  assign accept = o_state == O_IDLE && pas_req && !(pas_read && rd_busy);
  assign pas_refused = pas_req && !accept && wait_cnt == pat_pkg::WAIT_MAX;
  assign pas_waitrequest = pas_req && !accept && !pas_refused;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      wait_cnt <= 3'h0;
    else if (pas_waitrequest)
      wait_cnt <= wait_cnt + 3'h1;
    else
      wait_cnt <= 3'h0;
  end

  function automatic logic [2:0] low_pos(input logic [BE_W-1:0] be);
    low_pos = 3'h0;
    for (int i = BE_W - 1; i >= 0; i--)
      if (be[i])
        low_pos = 3'(i);
  endfunction

  // outbound address forming
  always_comb
  begin
    xl = (tbl_rdata & ~low_mask) | ({{(32-AW){1'b0}}, o_addr} & low_mask);
    pos = low_pos(o_be);
    unique case (tbl_rdata[1:0])
      pat_pkg::SP_IO:
        next_pm_addr = {xl[31:3], (DATA64 ? pos[2] : xl[2]), pos[1:0]};
      pat_pkg::SP_CFG:
        if (xl[23:16] == 8'h00)
          next_pm_addr = {21'h1 << xl[15:11], xl[10:2], pat_pkg::CFG_T0};
        else
          next_pm_addr = {xl[31:2], pat_pkg::CFG_T1};
      pat_pkg::SP_MEM, pat_pkg::SP_RSV:
        next_pm_addr = xl;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      o_state <= O_IDLE;
      o_addr <= '0;
      o_be <= '0;
      o_read <= 1'b0;
    end
    else
    begin
      unique case (o_state)
        O_IDLE:
          if (accept)
          begin
            o_state <= O_LOOK;
            o_addr <= pas_addr;
            o_be <= pas_byteen;
            o_read <= pas_read;
          end
        O_LOOK:
          o_state <= tbl_rdata[1:0] == pat_pkg::SP_RSV ? O_IDLE : O_ISSUE;
        O_ISSUE:
          if (pm_ready)
            o_state <= O_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pm_addr <= '0;
      pm_space <= 2'h0;
      pm_read <= 1'b0;
      pm_byteen <= '0;
    end
    else if (o_state == O_LOOK)
    begin
      pm_addr <= next_pm_addr;
      pm_space <= tbl_rdata[1:0];
      pm_read <= o_read;
      pm_byteen <= o_be;
    end
  end

  assign pm_valid = o_state == O_ISSUE;
  assign pas_space_err = o_state == O_LOOK && tbl_rdata[1:0] == pat_pkg::SP_RSV;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      rd_busy <= 1'b0;
    else if (pm_valid && pm_ready && pm_read)
      rd_busy <= 1'b1;
    else if (pm_rd_done)
      rd_busy <= 1'b0;
  end

  // --------------------------------------------------------------
  // pci target side: bar match and delayed reads
  // --------------------------------------------------------------
  logic [pat_pkg::NUM_BARS-1:0] hit;
  logic [31:0] bmask [pat_pkg::NUM_BARS];
  logic [31:0] lbase [pat_pkg::NUM_BARS];
  logic [1:0] hit_idx, t_bar;
  logic [31:0] t_raw, t_addr, buf_rdata;
  logic [pat_pkg::LEN_W-1:0] t_len, wptr, rptr, next_rptr;
  logic hit_any, primed, cmd_sent, start_rd, start_wr, resume, lm_go, beat_out, buf_wen;

  for (genvar i = 0; i < pat_pkg::NUM_BARS; i++)
  begin : g_bar
    assign bmask[i] = BAR_MASK[i*32 +: 32];
    assign lbase[i] = LOCAL_BASE[i*32 +: 32];
    assign hit[i] = ((tgt_addr ^ bar_base[i*32 +: 32]) & bmask[i]) == 32'h0;
  end

  always_comb
  begin
    hit_idx = 2'h0;
    for (int i = pat_pkg::NUM_BARS - 1; i >= 0; i--)
      if (hit[i])
        hit_idx = 2'(i);
  end

  assign hit_any = |hit;
  assign start_rd = t_state == T_IDLE && tgt_req && hit_any && tgt_read;
  assign start_wr = t_state == T_IDLE && tgt_req && hit_any && !tgt_read;
  assign resume = t_state == T_RHOLD && tgt_req && tgt_read && tgt_addr == t_raw;
  assign tgt_accept = start_wr || resume;
  assign tgt_retry = tgt_req && hit_any && !tgt_accept;

  assign lm_go = (t_state == T_WDRAIN && primed) || (t_state == T_RFETCH && !cmd_sent);
  assign lm_valid = lm_go ? 3'(1 << t_bar) : 3'h0;
  assign lm_read = t_state == T_RFETCH;
  assign lm_wdata = buf_rdata;
  assign tgt_rvalid = t_state == T_RSEND && primed;
  assign tgt_rdata = buf_rdata;
  assign beat_out = (t_state == T_WDRAIN && primed && !lm_waitrequest) || (tgt_rvalid && tgt_rready);
  assign next_rptr = beat_out ? rptr + ONE : rptr;
  assign buf_wen = (t_state == T_WFILL && tgt_wvalid) || (t_state == T_RFETCH && cmd_sent && lm_rvalid);

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      t_state <= T_IDLE;
      t_bar <= 2'h0;
      t_raw <= '0;
      t_addr <= '0;
      t_len <= ONE;
    end
    else
    begin
      unique case (t_state)
        T_IDLE:
          if (start_rd || start_wr)
          begin
            t_state <= start_rd ? T_RFETCH : T_WFILL;
            t_bar <= hit_idx;
            t_raw <= tgt_addr;
            t_addr <= (tgt_addr & ~bmask[hit_idx]) | (lbase[hit_idx] & bmask[hit_idx]);
            t_len <= hit_idx == pat_pkg::BAR_PF ? tgt_len : ONE;
          end
        T_WFILL:
          if (tgt_wvalid && wptr == t_len - ONE)
            t_state <= T_WDRAIN;
        T_WDRAIN:
          if (beat_out && rptr == t_len - ONE)
            t_state <= T_IDLE;
        T_RFETCH:
          if (cmd_sent && lm_rvalid && wptr == t_len - ONE)
            t_state <= T_RHOLD;
        T_RHOLD:
          if (resume)
            t_state <= T_RSEND;
        T_RSEND:
          if (beat_out && rptr == t_len - ONE)
            t_state <= T_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wptr <= '0;
      rptr <= '0;
      primed <= 1'b0;
      cmd_sent <= 1'b0;
    end
    else
    begin
      wptr <= t_state == T_IDLE ? '0 : (buf_wen ? wptr + ONE : wptr);
      rptr <= t_state == T_IDLE ? '0 : next_rptr;
      primed <= t_state == T_WDRAIN || t_state == T_RSEND;
      cmd_sent <= t_state == T_RFETCH && (cmd_sent || !lm_waitrequest);
    end
  end

  assign lm_addr = t_addr;
  assign lm_burst = t_len;

  // dual-port buffer between pci data phases and local bursts
  pat_dpram #(.W(32), .DEPTH(BUF_DEPTH), .AW(BW)) u_buf (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .wen(buf_wen),
    .waddr(wptr[BW-1:0]),
    .wdata(t_state == T_WFILL ? tgt_wdata : lm_rdata),
    .raddr(next_rptr[BW-1:0]),
    .rdata(buf_rdata)
  );

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  one_read_a: assert property (pm_valid && pm_read |-> !rd_busy)
    else $error("second outbound read while one is in flight");
  wait_limit_a: assert property (pas_waitrequest [*6] |=> !pas_waitrequest)
    else $error("wait state longer than six cycles");
  single_np_a: assert property ((lm_valid[1] || lm_valid[2]) |-> lm_burst == 8'h01)
    else $error("burst on non-prefetchable or io port");
  busy_retry_a: assert property (tgt_req && hit_any && tgt_read && t_state != T_RHOLD |-> tgt_retry)
    else $error("read taken while a delayed read is active");
  bar_base_a: assert property (|lm_valid |-> ((lm_addr ^ lbase[t_bar]) & bmask[t_bar]) == 32'h0)
    else $error("inbound address lost its local base");
  pass_low_a: assert property (pm_valid && pm_space == pat_pkg::SP_MEM
    |-> (pm_addr & low_mask) == ({{(32-AW){1'b0}}, o_addr} & low_mask))
    else $error("low address bits altered");
  no_reserved_a: assert property (o_state == O_LOOK && tbl_rdata[1:0] == pat_pkg::SP_RSV
    |=> !pm_valid && o_state == O_IDLE)
    else $error("reserved space issued");
  type0_hot_a: assert property (pm_valid && pm_space == pat_pkg::SP_CFG && pm_addr[1:0] == pat_pkg::CFG_T0
    |-> $onehot0(pm_addr[31:11]))
    else $error("type 0 device select not one-hot");
  type1_bus_a: assert property (pm_valid && pm_space == pat_pkg::SP_CFG && pm_addr[1:0] == pat_pkg::CFG_T1
    |-> pm_addr[23:16] != 8'h00)
    else $error("type 1 request with bus zero");
  io_low_a: assert property (pm_valid && pm_space == pat_pkg::SP_IO && pm_byteen[0]
    |-> pm_addr[1:0] == 2'h0)
    else $error("io low bits do not point to first byte");

  delayed_read_c: cover property (start_rd ##[1:60] resume);
  refuse_c: cover property (pas_refused);
  cfg_type0_c: cover property (pm_valid && pm_space == pat_pkg::SP_CFG && pm_addr[1:0] == pat_pkg::CFG_T0);
  pf_burst_c: cover property (lm_valid[0] && lm_burst > 8'h01);
endmodule

// ---- dv/pat_far_model.sv ----
// pat_far_model: pci bus agent and local slave seen from the bridge
// assumes sys_clk domain; the bench sets the wait and holds read completion
`timescale 1ns/1ps
module pat_far_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // bench control
  input wire logic [1:0] wait_n,
  input wire logic hold_done,
  // pci master side
  input wire logic pm_valid,
  input wire logic pm_read,
  output logic pm_ready,
  output logic pm_rd_done,
  // local slave side
  input wire logic [2:0] lm_valid,
  input wire logic lm_read,
  input wire logic [7:0] lm_burst,
  output logic lm_waitrequest,
  output logic lm_rvalid,
  output logic [31:0] lm_rdata
);
  logic [1:0] pcnt;
  logic [1:0] lcnt;
  logic [2:0] dly;
  logic pend;
  logic lacc;
  logic [7:0] beats;
  assign lm_waitrequest = !lacc;
  // ----------------------------------------
  // pci side: ready after wait_n, read completion later
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pcnt <= 2'h0;
      pm_ready <= 1'h0;
      pend <= 1'h0;
      dly <= 3'h0;
      pm_rd_done <= 1'h0;
    end
    else
    begin
      pcnt <= (!pm_valid || pm_ready) ? 2'h0 : (pcnt != wait_n) ? pcnt + 2'h1 : pcnt;
      pm_ready <= pm_valid && !pm_ready && pcnt == wait_n;
      pm_rd_done <= pend && dly == 3'h0 && !hold_done;
      if (pm_valid && pm_ready && pm_read)
      begin
        pend <= 1'h1;
        dly <= 3'h3;
      end
      else if (pend && dly != 3'h0)
        dly <= dly - 3'h1;
      else if (pend && !hold_done)
        pend <= 1'h0;
    end
  end
  // ----------------------------------------
  // local slave: accept after wait_n, read beats count up from d0000000
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lcnt <= 2'h0;
      lacc <= 1'h0;
      beats <= 8'h0;
      lm_rvalid <= 1'h0;
      lm_rdata <= 32'h0;
    end
    else
    begin
      lcnt <= (lm_valid == 3'h0 || lacc) ? 2'h0 : (lcnt != wait_n) ? lcnt + 2'h1 : lcnt;
      lacc <= lm_valid != 3'h0 && !lacc && lcnt == wait_n;
      if (lm_valid != 3'h0 && lacc && lm_read)
      begin
        beats <= lm_burst;
        lm_rvalid <= 1'h1;
        lm_rdata <= 32'hd000_0000;
      end
      else if (beats > 8'h1)
      begin
        beats <= beats - 8'h1;
        lm_rdata <= lm_rdata + 32'h1;
      end
      else
      begin
        // idle data inverts every cycle, so it equals the last beat again every other cycle
        beats <= 8'h0;
        lm_rvalid <= 1'h0;
        lm_rdata <= ~lm_rdata;
      end
    end
  end
endmodule

// ---- dv/pat_bridge_tb.sv ----
// pat_bridge_tb: random and corner checks of the bridge translation logic
// assumes pat_far_model on the far side; 250 MHz sys_clk
`timescale 1ns/1ps
module pat_bridge_tb;
  localparam logic [95:0] MASKS = {32'hffff_0000, 32'hffff_f000, 32'hfff0_0000};
  localparam logic [95:0] BASES = {32'h0003_0000, 32'h0002_0000, 32'h0010_0000};
  logic sys_clk = 1'h0;
  logic resetn = 1'h0;
  logic ctl_write = 1'h0, ctl_from_pci = 1'h0, pas_read = 1'h0, pas_write = 1'h0;
  logic [15:0] ctl_addr = 16'h0;
  logic [31:0] ctl_wdata = 32'h0, tgt_addr = 32'h0, tgt_wdata = 32'h0;
  logic [19:0] pas_addr = 20'h0;
  logic [3:0] pas_byteen = 4'h1;
  logic pas_waitrequest, pas_refused, pas_space_err, pm_valid, pm_ready, pm_read, pm_rd_done;
  logic [1:0] pm_space;
  logic [31:0] pm_addr, tgt_rdata, lm_addr, lm_wdata, lm_rdata, seen_addr, seen_wdata;
  logic [3:0] pm_byteen;
  logic [95:0] bar_base = {32'ha000_0000, 32'h9000_0000, 32'h8000_0000};
  logic tgt_req = 1'h0, tgt_read = 1'h0, tgt_wvalid = 1'h0, tgt_rready = 1'h0;
  logic [7:0] tgt_len = 8'h1, lm_burst, seen_burst;
  logic tgt_accept, tgt_retry, tgt_rvalid, lm_read, lm_waitrequest, lm_rvalid, seen_read;
  logic [2:0] lm_valid, seen_valid;
  logic [1:0] wait_n = 2'h0;
  logic hold_done = 1'h0;
  int fail_count = 0;
  int comparisons = 0;

  pat_bridge #(.PAGE_BITS(12), .AW(20), .DATA64(1'h0), .BAR_MASK(MASKS), .LOCAL_BASE(BASES)) dut (
    .sys_clk, .resetn, .ctl_write, .ctl_addr, .ctl_wdata, .ctl_from_pci, .pas_read, .pas_write,
    .pas_addr, .pas_byteen, .pas_waitrequest, .pas_refused, .pas_space_err, .pm_valid, .pm_ready,
    .pm_read, .pm_space, .pm_addr, .pm_byteen, .pm_rd_done, .bar_base, .tgt_req, .tgt_read,
    .tgt_addr, .tgt_len, .tgt_accept, .tgt_retry, .tgt_wvalid, .tgt_wdata, .tgt_rvalid,
    .tgt_rready, .tgt_rdata, .lm_valid, .lm_read, .lm_addr, .lm_burst, .lm_wdata,
    .lm_waitrequest, .lm_rvalid, .lm_rdata);
  pat_far_model far (.sys_clk, .resetn, .wait_n, .hold_done, .pm_valid, .pm_read, .pm_ready,
    .pm_rd_done, .lm_valid, .lm_read, .lm_burst, .lm_waitrequest, .lm_rvalid, .lm_rdata);

  always #2 sys_clk = ~sys_clk;
  // last accepted local master command
  always @(posedge sys_clk)
    if (lm_valid != 3'h0 && !lm_waitrequest)
    begin
      seen_valid <= lm_valid;
      seen_addr <= lm_addr;
      seen_burst <= lm_burst;
      seen_wdata <= lm_wdata;
      seen_read <= lm_read;
    end

  // ----------------------------------------
  // compare and report
  // ----------------------------------------
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp, input string msg);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: %s flag %b", $time, msg, got);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic give_up(input string msg);
    fail_count++;
    $display("mismatch at %0t: timeout %s", $time, msg);
    print_verdict();
  endtask
  // ----------------------------------------
  // expectations and drivers
  // ----------------------------------------
  function automatic logic [31:0] xlat(input logic [31:0] e, input logic [19:0] a, input logic [3:0] be);
    logic [31:0] t;
    logic [1:0] lo;
    t = {e[31:12], a[11:0]};
    lo = be[0] ? 2'h0 : be[1] ? 2'h1 : be[2] ? 2'h2 : 2'h3;
    case (e[1:0])
      2'h2: return {t[31:2], lo};
      2'h3: return (t[23:16] != 8'h0) ? {t[31:2], 2'h1} : {21'h1 << t[15:11], t[10:2], 2'h0};
      default: return t;
    endcase
  endfunction
  function automatic logic [31:0] inb(input int b, input logic [31:0] a);
    return (a & ~MASKS[b*32+:32]) | (BASES[b*32+:32] & MASKS[b*32+:32]);
  endfunction
  task automatic tbl_wr(input logic [8:0] idx, input logic [31:0] d, input logic pci, input logic hi);
    ctl_write <= 1'h1;
    ctl_addr <= {4'h1, idx, hi, 2'h0};
    ctl_wdata <= d;
    ctl_from_pci <= pci;
    // strobe stays high across back-to-back writes; the caller lowers it
    @(posedge sys_clk);
  endtask
  task automatic pas_go(input logic rd, input logic [19:0] a, input logic [3:0] be, output logic serr);
    int n;
    pas_read <= rd;
    pas_write <= !rd;
    pas_addr <= a;
    pas_byteen <= be;
    for (n = 0; n < 8; n++)
    begin
      @(posedge sys_clk);
      if (pas_waitrequest === 1'h0)
        break;
    end
    if (n == 8)
      give_up("request");
    pas_read <= 1'h0;
    pas_write <= 1'h0;
    serr = 1'h0;
    for (n = 0; n < 12; n++)
    begin
      @(posedge sys_clk);
      serr = pas_space_err === 1'h1;
      if (serr || (pm_valid && pm_ready))
        break;
    end
    if (n == 12)
      give_up("issue");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    logic [31:0] e, ra;
    logic [19:0] a;
    logic [7:0] idx;
    logic [3:0] be;
    logic serr;
    int n, k;
    void'($urandom(40));
    repeat (4) @(posedge sys_clk);
    resetn <= 1'h1;
    for (int i = 0; i < 24; i++)
    begin
      idx = 8'($urandom_range(255, 0));
      e = $urandom;
      e[1:0] = 2'(i);
      if (i[2])
        e[23:16] = 8'h0;
      a = {idx, 12'($urandom)};
      be = 4'($urandom_range(15, 1));
      wait_n <= 2'($urandom_range(2, 0));
      tbl_wr({1'h0, idx}, e, 1'h0, 1'h0);
      tbl_wr({1'h0, idx}, ~e, 1'h1, 1'h0);
      tbl_wr({1'h0, idx}, ~e, 1'h0, 1'h1);
      ctl_write <= 1'h0;
      pas_go(i[3], a, be, serr);
      chk_flag(serr, i[1:0] == 2'h1, "reserved space");
      if (!serr)
      begin
        chk_val(pm_addr, xlat(e, a, be), "pci address");
        chk_val(32'(pm_space), 32'(e[1:0]), "space");
        chk_flag(pm_read, i[3], "direction");
        chk_val(32'(pm_byteen), 32'(be), "byte enables");
      end
    end
    // second read while the first is still outstanding
    hold_done <= 1'h1;
    pas_go(1'h1, a, 4'hf, serr);
    pas_read <= 1'h1;
    for (n = 0; n < 10; n++)
    begin
      @(posedge sys_clk);
      if (pas_waitrequest === 1'h0)
        break;
    end
    chk_val(32'(n), 32'h6, "wait cycles");
    chk_flag(pas_refused, 1'h1, "refused");
    pas_read <= 1'h0;
    hold_done <= 1'h0;
    // target write to the non-prefetchable bar
    tgt_req <= 1'h1;
    tgt_addr <= 32'h9000_0000 | ($urandom & 32'hffc);
    tgt_len <= 8'h4;
    @(posedge sys_clk);
    chk_flag(tgt_accept, 1'h1, "write accept");
    ra = tgt_addr;
    tgt_req <= 1'h0;
    tgt_wvalid <= 1'h1;
    tgt_wdata <= 32'h5a5a_0001;
    @(posedge sys_clk);
    tgt_wvalid <= 1'h0;
    repeat (12) @(posedge sys_clk);
    chk_val(32'(seen_valid), 32'h2, "port");
    chk_val(32'(seen_burst), 32'h1, "single");
    chk_val(seen_addr, inb(1, ra), "local address");
    chk_val(seen_wdata, 32'h5a5a_0001, "write data");
    chk_flag(seen_read, 1'h0, "write direction");
    // delayed read on the prefetchable bar, others retried meanwhile
    ra = 32'h8000_0000 | ($urandom & 32'hffffc);
    tgt_req <= 1'h1;
    tgt_read <= 1'h1;
    tgt_addr <= ra;
    @(posedge sys_clk);
    chk_flag(tgt_retry, 1'h1, "first read");
    tgt_addr <= 32'h9000_0010;
    @(posedge sys_clk);
    chk_flag(tgt_retry, 1'h1, "other read");
    tgt_read <= 1'h0;
    @(posedge sys_clk);
    chk_flag(tgt_retry, 1'h1, "write pending");
    tgt_req <= 1'h0;
    for (n = 0; n < 40; n++)
    begin
      @(posedge sys_clk);
      tgt_req <= !tgt_req;
      tgt_read <= 1'h1;
      tgt_addr <= ra;
      if (tgt_req && tgt_accept === 1'h1)
        break;
    end
    if (n == 40)
      give_up("delayed read");
    chk_val(32'(seen_valid), 32'h1, "port");
    chk_flag(seen_read, 1'h1, "fetch direction");
    chk_val(32'(seen_burst), 32'h4, "burst");
    chk_val(seen_addr, inb(0, ra), "local address");
    tgt_rready <= 1'h1;
    k = 0;
    for (n = 0; n < 20 && k < 4; n++)
    begin
      @(posedge sys_clk);
      if (tgt_rvalid === 1'h1)
      begin
        chk_val(tgt_rdata, 32'hd000_0000 + 32'(k), "read beat");
        k++;
      end
    end
    chk_val(32'(k), 32'h4, "beats");
    print_verdict();
  end
endmodule
